// File: awe_write_engine.sv
// ATA PIO write command engine: task file over AXI4-Lite, sector data out to media.
// Assumes a media back end on the same clock that pulses media_done after each commit.
//
// Notes on behaviour
// R1 - Busy within 400 ns of acceptance
// R2 - Write-multiple interrupts once per block only
// R3 - Data request checked only at block start
// R4 - Full blocks, then remainder partial block
// R5 - Abort multiple without setup or when disabled
// R6 - Error stops at failing sector, nothing after
// R7 - Interrupt with data request at block start
// R8 - Error leaves failing address and residual count
// R9 - Block size of one, advertised
// R10 - C5h write-multiple, 28-bit address, features unused
// R11 - 39h: 48-bit address, 16-bit count, byte pairs
// R12 - High-order select reads earlier-written byte
// R13 - Any task-file access clears high-order select
// R14 - 48-bit error address, 16-bit residual
// R15 - CDh write-multiple without implied erase
// R16 - Host should pre-erase before no-erase write
// R17 - 30h/31h write-sectors, zero count means 256
// R18 - Write-sectors: busy, then request, no interrupt
// R19 - Host waits for busy clear before data
// R20 - Per sector: busy, then request plus interrupt
// R21 - After last sector busy until completion interrupt
// R22 - Write-sectors error leaves failing location
// R23 - Drive-select bit picks LBA or CHS
// R24 - Zero count on 28-bit multiple means 256
`timescale 1ns/100ps
module awe_write_engine (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Media back end
  output awe_pkg::awe_media_type media,
  input wire logic media_done,
  input wire logic media_err,
  // Host interrupt line
  output logic intrq
);
  localparam int BSY_CYC = awe_pkg::BUSY_MAX_CYC;

  awe_pkg::awe_eng_type q_ff;
  awe_pkg::awe_eng_type nxt_q;

  logic [awe_pkg::NUM_PAIRS-1:0] pair_wr;
  logic [awe_pkg::NUM_PAIRS-1:0][7:0] pair_cur;
  logic [awe_pkg::NUM_PAIRS-1:0][7:0] pair_prev;
  logic [awe_pkg::NUM_PAIRS-1:0][15:0] pair_load;
  logic wr_fire;
  logic rd_fire;
  logic tf_wr;
  logic tf_rd;
  logic devctl_wr;
  logic cmd_go;
  logic [7:0] opc;
  logic is_ws;
  logic is_mult;
  logic mult_ok;
  logic [16:0] nxt_remain;
  logic [31:0] rd_val;
  logic [1:0] rd_resp;
  logic [7:0] status_val;
  logic [7:0] error_val;

  assign s_axi_awready = !q_ff.aw_got && !q_ff.bvalid;
  assign s_axi_wready = !q_ff.w_got && !q_ff.bvalid;
  assign s_axi_arready = !q_ff.rvalid;
  assign wr_fire = q_ff.aw_got && q_ff.w_got && !q_ff.bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign tf_wr = wr_fire && q_ff.awaddr >= awe_pkg::OFS_FEATURE_ERROR
    && q_ff.awaddr <= awe_pkg::OFS_COMMAND_STATUS;
  assign tf_rd = rd_fire && s_axi_araddr >= awe_pkg::OFS_FEATURE_ERROR
    && s_axi_araddr <= awe_pkg::OFS_COMMAND_STATUS;
  assign devctl_wr = wr_fire && q_ff.wstrb[0] && q_ff.awaddr == awe_pkg::OFS_DEVICE_CONTROL;
  assign cmd_go = wr_fire && q_ff.wstrb[0] && q_ff.awaddr == awe_pkg::OFS_COMMAND_STATUS
    && q_ff.st == awe_pkg::ST_IDLE;
  assign opc = q_ff.wdata[7:0];
  // R10 opcode decode
  // R15 no-erase variant
  // R17 write-sectors pair
  assign is_ws = opc == awe_pkg::OPC_WRITE_SECTORS || opc == awe_pkg::OPC_WRITE_SECTORS_ALT;
  assign is_mult = opc == awe_pkg::OPC_WRITE_MULTIPLE || opc == awe_pkg::OPC_WRITE_MULTIPLE_EXT
    || opc == awe_pkg::OPC_WRITE_MULTIPLE_NO_ERASE;
  assign mult_ok = q_ff.mult_set && !q_ff.mult_dis;
  assign nxt_remain = q_ff.remain - 17'h00001;

  assign status_val = {q_ff.busy, 1'b1, 1'b0, 1'b1, q_ff.data_request_flag, 2'h0, q_ff.err};
  assign error_val = {1'b0, q_ff.media_fault, 3'h0, q_ff.abort_err, 2'h0};

  // R14 error address and residual written back as byte pairs
  assign pair_load[awe_pkg::PAIR_COUNT] = q_ff.remain[15:0];
  assign pair_load[awe_pkg::PAIR_LOW] = {q_ff.lba[31:24], q_ff.lba[7:0]};
  assign pair_load[awe_pkg::PAIR_MID] = {q_ff.lba[39:32], q_ff.lba[15:8]};
  assign pair_load[awe_pkg::PAIR_UP] = {q_ff.lba[47:40], q_ff.lba[23:16]};

  // R11 each write pushes the current byte behind it
  for (genvar gi = 0; gi < awe_pkg::NUM_PAIRS; gi++) begin : g_pair
    assign pair_wr[gi] = wr_fire && q_ff.wstrb[0] && q_ff.awaddr == awe_pkg::PAIR_OFS[gi];
    awe_tf_pair u_pair (
      .aclk(aclk),
      .aresetn(aresetn),
      .bus_wr(pair_wr[gi]),
      .bus_byte(q_ff.wdata[7:0]),
      .eng_ld(q_ff.tf_ld),
      .eng_val(pair_load[gi]),
      .cur(pair_cur[gi]),
      .prev(pair_prev[gi])
    );
  end

  // Read mux
  always_comb begin
    rd_val = 32'h0;
    rd_resp = awe_pkg::RESP_OKAY;
    case (s_axi_araddr)
      awe_pkg::OFS_DATA: rd_val = 32'h0;
      awe_pkg::OFS_FEATURE_ERROR: rd_val = {24'h0, error_val};
      // R12 high-order select picks the earlier byte
      awe_pkg::OFS_TRANSFER_LENGTH: rd_val = {24'h0, q_ff.high_order_byte_select ? pair_prev[0] : pair_cur[0]};
      awe_pkg::OFS_LBA_LOW: rd_val = {24'h0, q_ff.high_order_byte_select ? pair_prev[1] : pair_cur[1]};
      awe_pkg::OFS_LBA_MIDDLE: rd_val = {24'h0, q_ff.high_order_byte_select ? pair_prev[2] : pair_cur[2]};
      awe_pkg::OFS_LBA_UPPER: rd_val = {24'h0, q_ff.high_order_byte_select ? pair_prev[3] : pair_cur[3]};
      awe_pkg::OFS_DEVICE_SELECT: rd_val = {24'h0, q_ff.dev_sel};
      awe_pkg::OFS_COMMAND_STATUS: rd_val = {24'h0, status_val};
      awe_pkg::OFS_DEVICE_CONTROL: rd_val = {24'h0, q_ff.high_order_byte_select, 7'h0};
      awe_pkg::OFS_MULTIPLE_CFG: rd_val = {30'h0, q_ff.mult_dis, q_ff.mult_set};
      // R9 block size advertised to software
      awe_pkg::OFS_IDENT_BLOCK: rd_val = {24'h0, awe_pkg::MULT_BLOCK};
      default: rd_resp = awe_pkg::RESP_DECERR;
    endcase
  end

  always_comb begin
    nxt_q = q_ff;
    nxt_q.commit = 1'b0;
    nxt_q.wvalid = 1'b0;
    nxt_q.tf_ld = 1'b0;
    // Bus channels
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_q.aw_got = 1'b1;
      nxt_q.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_q.w_got = 1'b1;
      nxt_q.wdata = s_axi_wdata;
      nxt_q.wstrb = s_axi_wstrb;
    end
    if (q_ff.bvalid && s_axi_bready) begin
      nxt_q.bvalid = 1'b0;
    end
    if (wr_fire) begin
      nxt_q.aw_got = 1'b0;
      nxt_q.w_got = 1'b0;
      nxt_q.bvalid = 1'b1;
      nxt_q.bresp = q_ff.awaddr > awe_pkg::OFS_IDENT_BLOCK || q_ff.awaddr[1:0] != 2'h0
        ? awe_pkg::RESP_DECERR : awe_pkg::RESP_OKAY;
    end
    if (q_ff.rvalid && s_axi_rready) begin
      nxt_q.rvalid = 1'b0;
    end
    if (rd_fire) begin
      nxt_q.rvalid = 1'b1;
      nxt_q.rdata = rd_val;
      nxt_q.rresp = rd_resp;
      // Status read acknowledges the interrupt
      if (s_axi_araddr == awe_pkg::OFS_COMMAND_STATUS) begin
        nxt_q.intrq = 1'b0;
      end
    end
    // R13 task-file access drops the select
    if (tf_wr || tf_rd) begin
      nxt_q.high_order_byte_select = 1'b0;
    end
    if (devctl_wr) begin
      nxt_q.high_order_byte_select = q_ff.wdata[awe_pkg::DEVCTL_HOB_BIT];
    end
    if (wr_fire && q_ff.wstrb[0]) begin
      case (q_ff.awaddr)
        // Feature byte stored only, unused by these commands
        awe_pkg::OFS_FEATURE_ERROR: nxt_q.feature = q_ff.wdata[7:0];
        awe_pkg::OFS_DEVICE_SELECT: nxt_q.dev_sel = q_ff.wdata[7:0];
        awe_pkg::OFS_MULTIPLE_CFG: begin
          nxt_q.mult_set = q_ff.wdata[awe_pkg::CFG_SET_BIT];
          nxt_q.mult_dis = q_ff.wdata[awe_pkg::CFG_DIS_BIT];
        end
        default: ;
      endcase
    end
    // Command acceptance
    if (cmd_go) begin
      nxt_q.intrq = 1'b0;
      nxt_q.err = 1'b0;
      nxt_q.abort_err = 1'b0;
      nxt_q.media_fault = 1'b0;
      if ((is_mult && !mult_ok) || !(is_mult || is_ws)) begin
        // R5 abort without setup or when disabled
        nxt_q.err = 1'b1;
        nxt_q.abort_err = 1'b1;
        nxt_q.intrq = 1'b1;
      end else begin
        // R1 busy on the next edge, well inside the limit
        nxt_q.st = awe_pkg::ST_START;
        nxt_q.busy = 1'b1;
        nxt_q.data_request_flag = 1'b0;
        nxt_q.mult = is_mult;
        nxt_q.ext = opc == awe_pkg::OPC_WRITE_MULTIPLE_EXT;
        nxt_q.no_erase = opc == awe_pkg::OPC_WRITE_MULTIPLE_NO_ERASE;
        if (opc == awe_pkg::OPC_WRITE_MULTIPLE_EXT) begin
          // R11 earlier bytes form the upper half
          nxt_q.lba_mode = 1'b1;
          nxt_q.lba = {pair_prev[3], pair_prev[2], pair_prev[1], pair_cur[3], pair_cur[2], pair_cur[1]};
          nxt_q.remain = {pair_prev[0], pair_cur[0]} == 16'h0
            ? awe_pkg::COUNT48_ZERO : {1'b0, pair_prev[0], pair_cur[0]};
        end else begin
          // R23 addressing mode from the drive-select bit
          nxt_q.lba_mode = q_ff.dev_sel[awe_pkg::DEVSEL_LBA_BIT];
          // R10 head nibble plus three address bytes
          nxt_q.lba = {20'h0, q_ff.dev_sel[3:0], pair_cur[3], pair_cur[2], pair_cur[1]};
          // R24 zero count means 256
          // R17 same for write-sectors
          nxt_q.remain = pair_cur[0] == 8'h0 ? awe_pkg::COUNT28_ZERO : {9'h0, pair_cur[0]};
        end
      end
    end
    // Sequencer
    case (q_ff.st)
      awe_pkg::ST_IDLE: ;
      awe_pkg::ST_START: begin
        // R18 busy drops, request rises for the first sector
        nxt_q.st = awe_pkg::ST_XFER;
        nxt_q.busy = 1'b0;
        nxt_q.data_request_flag = 1'b1;
        nxt_q.word_cnt = 7'h0;
        // R4 first block is full or the partial remainder
        nxt_q.blk_left = q_ff.remain > {9'h0, awe_pkg::MULT_BLOCK} ? awe_pkg::MULT_BLOCK : q_ff.remain[7:0];
        // R7 interrupt with the block's request; write-sectors has none here
        nxt_q.intrq = q_ff.mult;
      end
      awe_pkg::ST_XFER: begin
        // Data ignored unless a request is open
        if (wr_fire && q_ff.awaddr == awe_pkg::OFS_DATA) begin
          nxt_q.wvalid = 1'b1;
          nxt_q.mdata = q_ff.wdata;
          nxt_q.word_cnt = q_ff.word_cnt + 7'h1;
          if (q_ff.word_cnt == awe_pkg::WORD_LAST) begin
            // R20 sector buffered: busy up, request down
            nxt_q.st = awe_pkg::ST_COMMIT;
            nxt_q.busy = 1'b1;
            nxt_q.data_request_flag = 1'b0;
            nxt_q.commit = 1'b1;
          end
        end
      end
      awe_pkg::ST_COMMIT: begin
        if (media_done) begin
          if (media_err) begin
            // R6 stop at the failing sector
            // R8 failing address and residual go back
            // R22 same for write-sectors
            nxt_q.st = awe_pkg::ST_IDLE;
            nxt_q.busy = 1'b0;
            nxt_q.err = 1'b1;
            nxt_q.media_fault = 1'b1;
            nxt_q.intrq = 1'b1;
            nxt_q.tf_ld = 1'b1;
            if (!q_ff.ext) begin
              nxt_q.dev_sel[3:0] = q_ff.lba[27:24];
            end
          end else if (nxt_remain == 17'h0) begin
            // R21 completion: busy clears with the interrupt
            nxt_q.st = awe_pkg::ST_IDLE;
            nxt_q.busy = 1'b0;
            nxt_q.intrq = 1'b1;
            nxt_q.remain = nxt_remain;
            nxt_q.tf_ld = 1'b1;
            if (!q_ff.ext) begin
              nxt_q.dev_sel[3:0] = q_ff.lba[27:24];
            end
          end else begin
            nxt_q.st = awe_pkg::ST_XFER;
            nxt_q.busy = 1'b0;
            nxt_q.data_request_flag = 1'b1;
            nxt_q.word_cnt = 7'h0;
            nxt_q.remain = nxt_remain;
            nxt_q.lba = q_ff.lba + 48'h1;
            nxt_q.blk_left = q_ff.blk_left - 8'h1;
            if (q_ff.blk_left == 8'h1) begin
              // R2 one interrupt per block
              // R3 request qualified again only here
              // R20 next buffer ready
              nxt_q.intrq = 1'b1;
              nxt_q.blk_left = nxt_remain > {9'h0, awe_pkg::MULT_BLOCK}
                ? awe_pkg::MULT_BLOCK : nxt_remain[7:0];
            end
          end
        end
      end
      default: nxt_q.st = awe_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_ff <= '0;
      q_ff.st <= awe_pkg::ST_IDLE;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign s_axi_bresp = q_ff.bresp;
  assign s_axi_bvalid = q_ff.bvalid;
  assign s_axi_rdata = q_ff.rdata;
  assign s_axi_rresp = q_ff.rresp;
  assign s_axi_rvalid = q_ff.rvalid;
  assign intrq = q_ff.intrq;
  assign media.wvalid = q_ff.wvalid;
  assign media.wdata = q_ff.mdata;
  assign media.commit = q_ff.commit;
  assign media.lba = q_ff.lba;
  assign media.no_erase = q_ff.no_erase;
  assign media.lba_mode = q_ff.lba_mode;

  // Checks
  logic [7:0] remain_lo;
  logic [7:0] cnt_cur;
  assign remain_lo = q_ff.remain[7:0];
  assign cnt_cur = pair_cur[awe_pkg::PAIR_COUNT];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_mult_go;
    cmd_go && is_mult && mult_ok;
  endsequence
  sequence s_ws_go;
    cmd_go && is_ws;
  endsequence
  sequence s_busy_only;
    q_ff.busy && !q_ff.data_request_flag;
  endsequence
  sequence s_sector_ok;
    q_ff.st == awe_pkg::ST_COMMIT && media_done && !media_err;
  endsequence

  property p_busy_soon;
    s_mult_go |-> ##[1:BSY_CYC] q_ff.busy;
  endproperty
  a_busy_soon: assert property (p_busy_soon) else $error("busy late after command"); // R1

  property p_block_irq;
    s_mult_go |-> ##1 s_busy_only ##1 (q_ff.data_request_flag && !q_ff.busy && q_ff.intrq);
  endproperty
  a_block_irq: assert property (p_block_irq) else $error("no interrupt at block start"); // R7

  property p_ws_first;
    s_ws_go |-> ##1 s_busy_only ##1 (q_ff.data_request_flag && !q_ff.busy && !q_ff.intrq);
  endproperty
  a_ws_first: assert property (p_ws_first) else $error("bad first sector handshake"); // R18

  property p_abort;
    cmd_go && is_mult && !mult_ok |=> q_ff.err && q_ff.abort_err && !q_ff.busy && q_ff.st == awe_pkg::ST_IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("multiple not aborted"); // R5

  property p_next_sector;
    s_sector_ok ##0 (q_ff.remain > 17'h1) |=> q_ff.data_request_flag && !q_ff.busy && q_ff.intrq && q_ff.word_cnt == 7'h0;
  endproperty
  a_next_sector: assert property (p_next_sector) else $error("next sector not offered"); // R20

  property p_done;
    s_sector_ok ##0 (q_ff.remain == 17'h1) |=> !q_ff.busy && !q_ff.data_request_flag && q_ff.intrq;
  endproperty
  a_done: assert property (p_done) else $error("completion not signalled"); // R21

  property p_commit_busy;
    q_ff.st == awe_pkg::ST_COMMIT |-> q_ff.busy && !q_ff.data_request_flag;
  endproperty
  a_commit_busy: assert property (p_commit_busy) else $error("request open during commit"); // R21

  property p_err_residual;
    q_ff.st == awe_pkg::ST_COMMIT && media_done && media_err
      |=> (q_ff.st == awe_pkg::ST_IDLE && q_ff.err && !q_ff.data_request_flag) ##1 (cnt_cur == $past(remain_lo, 2));
  endproperty
  a_err_residual: assert property (p_err_residual) else $error("residual count wrong"); // R8

  property p_hob_clear;
    (tf_wr || tf_rd) && !devctl_wr |=> !q_ff.high_order_byte_select;
  endproperty
  a_hob_clear: assert property (p_hob_clear) else $error("select not cleared"); // R13

  property p_zero_count;
    cmd_go && (is_ws || (is_mult && mult_ok)) && opc != awe_pkg::OPC_WRITE_MULTIPLE_EXT
      && cnt_cur == 8'h0 |=> q_ff.remain == awe_pkg::COUNT28_ZERO;
  endproperty
  a_zero_count: assert property (p_zero_count) else $error("zero count not 256"); // R24
endmodule : awe_write_engine

// File: awe_pkg.sv
// Constants, register map and carrier types of the ATA PIO write command engine.
// Assumes one 200 MHz clock and a 32-bit AXI4-Lite register port.
package awe_pkg;

  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int BUSY_MAX_NS = 400;
  localparam int BUSY_MAX_CYC = BUSY_MAX_NS / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_FEATURE_ERROR = 8'h04;
  localparam logic [7:0] OFS_TRANSFER_LENGTH = 8'h08;
  localparam logic [7:0] OFS_LBA_LOW = 8'h0c;
  localparam logic [7:0] OFS_LBA_MIDDLE = 8'h10;
  localparam logic [7:0] OFS_LBA_UPPER = 8'h14;
  localparam logic [7:0] OFS_DEVICE_SELECT = 8'h18;
  localparam logic [7:0] OFS_COMMAND_STATUS = 8'h1c;
  localparam logic [7:0] OFS_DEVICE_CONTROL = 8'h20;
  localparam logic [7:0] OFS_MULTIPLE_CFG = 8'h24;
  localparam logic [7:0] OFS_IDENT_BLOCK = 8'h28;

  // Byte-pair registers, index order count, low, middle, upper
  localparam int NUM_PAIRS = 4;
  localparam int PAIR_COUNT = 0;
  localparam int PAIR_LOW = 1;
  localparam int PAIR_MID = 2;
  localparam int PAIR_UP = 3;
  localparam logic [3:0][7:0] PAIR_OFS = {OFS_LBA_UPPER, OFS_LBA_MIDDLE, OFS_LBA_LOW, OFS_TRANSFER_LENGTH};

  // Opcodes
  localparam logic [7:0] OPC_WRITE_SECTORS = 8'h30;
  localparam logic [7:0] OPC_WRITE_SECTORS_ALT = 8'h31;
  localparam logic [7:0] OPC_WRITE_MULTIPLE = 8'hc5;
  localparam logic [7:0] OPC_WRITE_MULTIPLE_EXT = 8'h39;
  localparam logic [7:0] OPC_WRITE_MULTIPLE_NO_ERASE = 8'hcd;

  // Transfer geometry
  localparam logic [6:0] WORD_LAST = 7'h7f;
  localparam logic [7:0] MULT_BLOCK = 8'h01;
  localparam logic [16:0] COUNT28_ZERO = 17'h00100;
  localparam logic [16:0] COUNT48_ZERO = 17'h10000;

  // Field positions
  localparam int STS_BUSY_BIT = 7;
  localparam int STS_READY_BIT = 6;
  localparam int STS_SEEK_BIT = 4;
  localparam int STS_DRQ_BIT = 3;
  localparam int STS_ERR_BIT = 0;
  localparam int ERR_ABORT_BIT = 2;
  localparam int ERR_MEDIA_BIT = 6;
  localparam int DEVCTL_HOB_BIT = 7;
  localparam int DEVSEL_LBA_BIT = 6;
  localparam int CFG_SET_BIT = 0;
  localparam int CFG_DIS_BIT = 1;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_START = 4'h2,
    ST_XFER = 4'h4,
    ST_COMMIT = 4'h8
  } awe_fsm_type;

  typedef struct packed {
    logic [7:0] prev;
    logic [7:0] cur;
  } awe_pair_type;

  typedef struct packed {
    logic wvalid;
    logic [31:0] wdata;
    logic commit;
    logic [47:0] lba;
    logic no_erase;
    logic lba_mode;
  } awe_media_type;

  typedef struct packed {
    awe_fsm_type st;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic busy;
    logic data_request_flag;
    logic err;
    logic abort_err;
    logic media_fault;
    logic intrq;
    logic ext;
    logic mult;
    logic no_erase;
    logic lba_mode;
    logic high_order_byte_select;
    logic [7:0] dev_sel;
    logic [7:0] feature;
    logic mult_set;
    logic mult_dis;
    logic [47:0] lba;
    logic [16:0] remain;
    logic [7:0] blk_left;
    logic [6:0] word_cnt;
    logic commit;
    logic wvalid;
    logic [31:0] mdata;
    logic tf_ld;
  } awe_eng_type;

endpackage : awe_pkg

// File: awe_tf_pair.sv
// One task-file byte register with its earlier-written byte behind it.
// A bus write in the same cycle as an engine load is dropped; the engine load wins.
`timescale 1ns/100ps
module awe_tf_pair (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus side
  input wire logic bus_wr,
  input wire logic [7:0] bus_byte,
  // Engine side
  input wire logic eng_ld,
  input wire logic [15:0] eng_val,
  // Contents
  output logic [7:0] cur,
  output logic [7:0] prev
);
  awe_pkg::awe_pair_type q_ff;
  awe_pkg::awe_pair_type nxt_q;

  always_comb begin
    nxt_q = q_ff;
    // Engine load wins; it happens in the cycle after busy clears, and bus writes are not blocked by busy
    if (eng_ld) begin
      nxt_q.prev = eng_val[15:8];
      nxt_q.cur = eng_val[7:0];
    end else if (bus_wr) begin
      nxt_q.prev = q_ff.cur;
      nxt_q.cur = bus_byte;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign cur = q_ff.cur;
  assign prev = q_ff.prev;
endmodule : awe_tf_pair

// File: awe_media_model.sv
// Media back end stand-in: answers each sector commit after a set delay.
// Assumes the engine's clock and a synchronous active-low reset.
`timescale 1ns/100ps
module awe_media_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Engine side
  input wire awe_pkg::awe_media_type media,
  output logic media_done,
  output logic media_err,
  // Bench control
  input wire logic fail,
  input wire logic [3:0] lat
);
  logic [3:0] cnt_ff;
  // Error line toggles outside done, never a stale level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= 4'h0;
      media_done <= 1'b0;
      media_err <= 1'b0;
    end else begin
      media_done <= (cnt_ff == 4'h1);
      media_err <= (cnt_ff == 4'h1) ? fail : !media_err;
      if (media.commit) begin
        cnt_ff <= lat;
      end else if (cnt_ff != 4'h0) begin
        cnt_ff <= cnt_ff - 4'h1;
      end
    end
  end
endmodule : awe_media_model

// File: tb.sv
// Bench for the write command engine: bus tasks and command sequences.
// Assumes the media model answers each commit.
`timescale 1ns/100ps
module tb;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, arvalid = 0, fail = 0, iq_d = 0;
  logic [31:0] wdata = 0, rdat, rdata;
  logic [3:0] lat = 4'h8;
  logic awready, wready, bvalid, arready, rvalid, intrq, mdone, merr;
  logic [1:0] bresp, rresp, resp;
  awe_pkg::awe_media_type media;
  int n_fail = 0, cmp_count = 0, n_irq = 0, n_com = 0, n_wv = 0, n0, i;
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    iq_d <= intrq;
    if (intrq && !iq_d) n_irq++;
    if (media.commit) n_com++;
    if (media.wvalid) n_wv++;
  end
  awe_write_engine i_awe_write_engine (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .media(media), .media_done(mdone), .media_err(merr), .intrq(intrq));
  awe_media_model i_awe_media_model (.aclk(aclk), .aresetn(aresetn), .media(media),
    .media_done(mdone), .media_err(merr), .fail(fail), .lat(lat));
  task automatic complete_run;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tmo(input int n);
    if (n >= 99) begin
      n_fail++;
      complete_run();
    end
  endtask : tmo
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ga, gw;
    ga = 0;
    gw = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    for (n = 0; n < 99 && !(ga && gw); n++) begin
      @(posedge aclk);
      ga |= awready;
      gw |= wready;
      awvalid <= !ga;
      wvalid <= !gw;
    end
    tmo(n);
    for (n = 0; n < 99 && bvalid !== 1'b1; n++) @(posedge aclk);
    tmo(n);
    resp = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    araddr <= a;
    arvalid <= 1;
    for (n = 0; n < 99 && !(arvalid && arready); n++) @(posedge aclk);
    arvalid <= 0;
    tmo(n);
    for (n = 0; n < 99 && rvalid !== 1'b1; n++) @(posedge aclk);
    tmo(n);
    d = rdata;
    resp = rresp;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    rd(a, rdat);
    chk(rdat, exp);
  endtask : rc
  // Poll status until busy clears, then compare
  task automatic ws(input logic [31:0] exp);
    int n;
    for (n = 0; n < 99; n++) begin
      rd(8'h1c, rdat);
      if (rdat[7] === 1'b0) break;
    end
    tmo(n);
    chk(rdat, exp);
  endtask : ws
  task automatic sect;
    for (int k = 0; k < 128; k++) wr(8'h00, 32'h0 + k);
  endtask : sect
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rc(8'h28, 32'h1);
    rd(8'h2c, rdat);
    chk(resp, 2'h3);
    for (i = 0; i < 4; i += 3) begin
      wr(8'h24, 32'(i));
      wr(8'h1c, 32'hc5);
      ws(32'h51);
      rc(8'h04, 32'h4);
    end
    wr(8'h24, 32'h1);
    wr(8'h18, 32'h45);
    wr(8'h14, 32'h12);
    wr(8'h10, 32'h34);
    wr(8'h0c, 32'h56);
    wr(8'h08, 32'h2);
    // Stray data word while idle must be dropped
    wr(8'h00, 32'h1);
    n0 = n_irq;
    wr(8'h1c, 32'hcd);
    ws(32'h58);
    sect();
    ws(32'h58);
    sect();
    ws(32'h50);
    chk(32'(n_irq - n0), 3);
    chk(32'(n_com), 2);
    chk(32'(n_wv), 256);
    chk(media.wdata, 32'h7f);
    chk(media.lba[27:0], 28'h5123457);
    chk(media.no_erase, 1);
    chk(media.lba_mode, 1);
    lat <= 4'h1;
    wr(8'h18, 32'h0);
    for (i = 8'h30; i < 8'h32; i++) begin
      wr(8'h08, 32'h1);
      n0 = n_irq;
      wr(8'h1c, 32'(i));
      ws(32'h58);
      chk(32'(n_irq - n0), 0);
      sect();
      ws(32'h50);
      chk(32'(n_irq - n0), 1);
      chk(media.lba[27:0], 28'h0123457);
      chk(media.lba_mode, 0);
    end
    fail <= 1;
    // Earlier byte first in each pair
    wr(8'h14, 32'hab);
    wr(8'h14, 32'h01);
    wr(8'h10, 32'hcd);
    wr(8'h10, 32'h02);
    wr(8'h0c, 32'hef);
    wr(8'h0c, 32'h03);
    wr(8'h08, 32'h00);
    wr(8'h08, 32'h02);
    wr(8'h1c, 32'h39);
    ws(32'h58);
    sect();
    ws(32'h51);
    chk(media.lba, 48'habcdef010203);
    rc(8'h04, 32'h40);
    rc(8'h08, 32'h2);
    rc(8'h0c, 32'h3);
    wr(8'h20, 32'h80);
    rc(8'h14, 32'hab);
    rc(8'h14, 32'h1);
    wr(8'h20, 32'h80);
    rc(8'h08, 32'h0);
    // Zero count means 256; second sector fails
    for (i = 0; i < 2; i++) begin
      fail <= 0;
      wr(8'h18, 32'h4a);
      wr(8'h08, 32'h0);
      wr(8'h1c, i ? 32'hc5 : 32'h30);
      ws(32'h58);
      sect();
      ws(32'h58);
      fail <= 1;
      sect();
      ws(32'h51);
      chk(media.lba[27:0], 28'ha010204 + i);
      rc(8'h0c, 32'h4 + i);
      rc(8'h18, 32'h4a);
      rc(8'h08, 32'hff);
    end
    complete_run();
  end
endmodule : tb
